// [design/bws_sequencer.sv]
// Block program wait and timer wait sequencer
// Contract
// - Satisfied wait condition lets block run normally
// - Unsatisfied wait: skip rest, jump to end
// - While waiting, execute nothing else of block
// - Satisfied later: resume after wait, then restart
// - Suspended block evaluates only its wait
// - Accept bits from the six bit areas
// - Without operand, plain wait uses prior logic result; inverted wait always uses inverted bit
// - Timer waits run preceding part on entry
// - Timer wait halts block until time elapses
// - Fault on non-BCD or bad indirect word
`timescale 1ns/10ps
`default_nettype none
`include "bws_regs.svh"

module bws_sequencer #(
  parameter int unsigned NBLK          = `BWS_NUM_BLOCKS,
  parameter int unsigned AW            = `BWS_ADDR_W,
  parameter int unsigned FAST_UNIT_CYC = `BWS_FAST_UNIT_MS * `BWS_CLK_KHZ,
  parameter int unsigned NORM_UNIT_CYC = `BWS_NORM_UNIT_MS * `BWS_CLK_KHZ
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_b_i,
  input  wire logic                ce_i,
  input  wire logic                instr_valid_i,
  input  wire logic [6:0]          block_i,
  input  wire logic [AW-1:0]       addr_i,
  input  wire bws_pkg::bws_kind_e  kind_i,
  input  wire logic                has_bit_i,
  input  wire bws_pkg::bws_area_e  area_i,
  input  wire logic                bit_i,
  input  wire logic                exec_cond_i,
  input  wire logic [15:0]         set_value_i,
  input  wire logic                dm_range_err_i,
  output logic                     ack_o,
  output logic                     exec_o,
  output logic                     skip_o,
  output logic                     resume_o,
  output logic [AW-1:0]            resume_addr_o,
  output logic                     fault_flag_o
);
  import bws_pkg::*;

  localparam int unsigned CW = `BWS_CNT_W;

  logic            suspended   [NBLK];
  logic [AW-1:0]   resume_addr [NBLK];
  logic            armed       [NBLK];
  logic            fast_sel    [NBLK];
  logic [CW-1:0]   remaining   [NBLK];
  logic [31:0]     fast_div;
  logic [31:0]     norm_div;
  logic            fast_tick;
  logic            norm_tick;
  logic            blk_ok;
  logic            blk_susp;
  logic            is_wait;
  logic            is_timer;
  logic            wait_met;
  logic            bcd_ok;
  logic            area_ok;
  logic [CW-1:0]   setv_bin;
  logic            next_exec;
  logic            next_skip;
  logic            next_resume;
  logic            next_fault;

  // Four BCD digits to a binary unit count
  function automatic logic [CW-1:0] bcd_to_bin(input logic [15:0] v);
    logic [CW-1:0] d3;
    logic [CW-1:0] d2;
    logic [CW-1:0] d1;
    logic [CW-1:0] d0;
    d3 = {{(CW-4){1'b0}}, v[15:12]};
    d2 = {{(CW-4){1'b0}}, v[11:8]};
    d1 = {{(CW-4){1'b0}}, v[7:4]};
    d0 = {{(CW-4){1'b0}}, v[3:0]};
    return CW'(d3 * CW'(1000) + d2 * CW'(100) + d1 * CW'(10) + d0);
  endfunction

  assign blk_ok   = 32'(block_i) < NBLK;
  assign blk_susp = blk_ok && suspended[block_i];
  assign is_wait  = (kind_i == bws_k_wait) || (kind_i == bws_k_wait_not);
  assign is_timer = (kind_i == bws_k_timer_normal) || (kind_i == bws_k_timer_fast);
  assign bcd_ok   = (set_value_i[15:12] <= `BWS_BCD_MAX) && (set_value_i[11:8] <= `BWS_BCD_MAX) &&
                    (set_value_i[7:4] <= `BWS_BCD_MAX) && (set_value_i[3:0] <= `BWS_BCD_MAX);
  assign setv_bin = bcd_to_bin(set_value_i);
  // Data memory words are no bit operand
  assign area_ok  = !has_bit_i || (area_i != bws_a_data_memory);

  // Condition: operand bit, inverted bit, or prior logic result
  always_comb begin
    if (kind_i == bws_k_wait_not) begin
      wait_met = !bit_i;
    end else if (has_bit_i) begin
      wait_met = bit_i;
    end else begin
      wait_met = exec_cond_i;
    end
  end

  // Unit prescalers shared by all block timers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fast_div  <= 32'h0000_0000;
      norm_div  <= 32'h0000_0000;
      fast_tick <= 1'b0;
      norm_tick <= 1'b0;
    end else if (ce_i) begin
      fast_tick <= (fast_div == FAST_UNIT_CYC - 1);
      norm_tick <= (norm_div == NORM_UNIT_CYC - 1);
      fast_div  <= (fast_div == FAST_UNIT_CYC - 1) ? 32'h0000_0000 : fast_div + 32'h0000_0001;
      norm_div  <= (norm_div == NORM_UNIT_CYC - 1) ? 32'h0000_0000 : norm_div + 32'h0000_0001;
    end
  end

  // Answer for the presented instruction
  always_comb begin
    next_exec   = 1'b0;
    next_skip   = 1'b0;
    next_resume = 1'b0;
    next_fault  = !area_ok;
    if (instr_valid_i) begin
      case (kind_i)
        bws_k_begin: begin
          next_resume = blk_susp;
          next_exec   = !blk_susp;
        end
        bws_k_wait, bws_k_wait_not: begin
          next_exec = 1'b1;
          next_skip = !wait_met;
        end
        bws_k_timer_normal, bws_k_timer_fast: begin
          next_exec  = 1'b1;
          next_fault = !area_ok || !bcd_ok || dm_range_err_i;
          if (blk_ok && armed[block_i]) begin
            next_skip = remaining[block_i] != {CW{1'b0}};
          end else begin
            next_skip = bcd_ok && !dm_range_err_i && (setv_bin != {CW{1'b0}});
          end
        end
        bws_k_end: begin
          next_exec = !blk_susp;
        end
        default: begin
          next_exec = !blk_susp;
        end
      endcase
    end
  end

  // Registered answer
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o         <= 1'b0;
      exec_o        <= 1'b0;
      skip_o        <= 1'b0;
      resume_o      <= 1'b0;
      resume_addr_o <= {AW{1'b0}};
      fault_flag_o  <= 1'b0;
    end else if (ce_i) begin
      ack_o         <= instr_valid_i;
      exec_o        <= next_exec;
      skip_o        <= next_skip;
      resume_o      <= next_resume;
      resume_addr_o <= blk_susp ? resume_addr[block_i] : {AW{1'b0}};
      fault_flag_o  <= instr_valid_i && next_fault;
    end
  end

  // Per-block suspend record and block timers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int b = 0; b < NBLK; b++) begin
        suspended[b]   <= 1'b0;
        resume_addr[b] <= {AW{1'b0}};
        armed[b]       <= 1'b0;
        fast_sel[b]    <= 1'b0;
        remaining[b]   <= {CW{1'b0}};
      end
    end else if (ce_i) begin
      for (int b = 0; b < NBLK; b++) begin
        if (remaining[b] != {CW{1'b0}} && (fast_sel[b] ? fast_tick : norm_tick)) begin
          remaining[b] <= remaining[b] - {{(CW-1){1'b0}}, 1'b1};
        end
      end
      if (instr_valid_i && blk_ok) begin
        case (kind_i)
          bws_k_wait, bws_k_wait_not: begin
            suspended[block_i]   <= !wait_met;
            resume_addr[block_i] <= addr_i;
          end
          bws_k_timer_normal, bws_k_timer_fast: begin
            if (!armed[block_i]) begin
              if (bcd_ok && !dm_range_err_i && setv_bin != {CW{1'b0}}) begin
                armed[block_i]       <= 1'b1;
                suspended[block_i]   <= 1'b1;
                resume_addr[block_i] <= addr_i;
                remaining[block_i]   <= setv_bin;
                fast_sel[block_i]    <= (kind_i == bws_k_timer_fast);
              end
            end else if (remaining[block_i] == {CW{1'b0}}) begin
              armed[block_i]     <= 1'b0;
              suspended[block_i] <= 1'b0;
            end
          end
          bws_k_end: begin
            if (!suspended[block_i]) begin
              armed[block_i] <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  chk_wait_met_runs: assert property (
    instr_valid_i && ce_i && is_wait && wait_met |=> exec_o && !skip_o)
    else $error("satisfied wait did not let the block run");

  chk_wait_unmet_skip: assert property (
    instr_valid_i && ce_i && blk_ok && is_wait && !wait_met |=> skip_o && suspended[$past(block_i)])
    else $error("unsatisfied wait did not skip and suspend");

  chk_suspend_no_exec: assert property (
    instr_valid_i && ce_i && blk_susp && (kind_i == bws_k_other) |=> ack_o && !exec_o)
    else $error("instruction of suspended block was executed");

  chk_resume_address: assert property (
    instr_valid_i && ce_i && blk_susp && (kind_i == bws_k_begin)
    |=> resume_o && !exec_o && (resume_addr_o == $past(resume_addr[block_i])))
    else $error("suspended block did not resume at its wait");

  chk_only_wait_evaluated: assert property (
    instr_valid_i && ce_i && blk_susp && is_wait |=> exec_o)
    else $error("wait of suspended block was not evaluated");

  chk_area_accepted: assert property (
    instr_valid_i && ce_i && is_wait && has_bit_i && (area_i != bws_a_data_memory) |=> !fault_flag_o)
    else $error("bit operand area refused");

  chk_logic_result: assert property (
    instr_valid_i && ce_i && (kind_i == bws_k_wait) && !has_bit_i |=> skip_o == !$past(exec_cond_i))
    else $error("wait without operand ignored the logic result");

  chk_first_entry_runs: assert property (
    instr_valid_i && ce_i && !blk_susp && (kind_i == bws_k_begin) |=> exec_o && !resume_o)
    else $error("first entry did not run the preceding part");

  chk_timer_holds: assert property (
    instr_valid_i && ce_i && is_timer && blk_ok && armed[block_i] && (remaining[block_i] != {CW{1'b0}})
    |=> skip_o && suspended[$past(block_i)])
    else $error("timer wait released before its time");

  chk_fast_full_scale: assert property (
    instr_valid_i && ce_i && blk_ok && (kind_i == bws_k_timer_fast) && !armed[block_i] &&
    (set_value_i == 16'h9999) && !dm_range_err_i && area_ok
    |=> !fault_flag_o && (remaining[$past(block_i)] == 14'h270F))
    else $error("fast timer full scale value not loaded");

  chk_bcd_fault: assert property (
    instr_valid_i && ce_i && is_timer && (!bcd_ok || dm_range_err_i) |=> fault_flag_o)
    else $error("bad set value did not raise the fault flag");

  chk_end_completes: assert property (
    instr_valid_i && ce_i && blk_ok && (kind_i == bws_k_end) && !suspended[block_i]
    |=> !suspended[$past(block_i)] && !armed[$past(block_i)])
    else $error("block end did not clear the block record");

  chk_timer_arm_skip: assert property (
    instr_valid_i && ce_i && is_timer && blk_ok && !armed[block_i] && bcd_ok && !dm_range_err_i &&
    (setv_bin != {CW{1'b0}}) |=> skip_o && suspended[$past(block_i)])
    else $error("timer wait did not halt its block");

  chk_wait_not_unmet: assert property (
    instr_valid_i && ce_i && (kind_i == bws_k_wait_not) && bit_i |=> skip_o)
    else $error("inverted wait with bit set did not skip");

  cov_wait_suspend: cover property (
    instr_valid_i && ce_i && is_wait && !wait_met ##1 skip_o);

  cov_resume: cover property (
    instr_valid_i && ce_i && blk_susp && (kind_i == bws_k_begin) ##1 resume_o);

  cov_timer_release: cover property (
    instr_valid_i && ce_i && is_timer && blk_ok && armed[block_i] && (remaining[block_i] == {CW{1'b0}}));

  cov_fault_raised: cover property (
    instr_valid_i && ce_i && is_timer && !bcd_ok ##1 fault_flag_o);

  cov_ce_frozen: cover property (
    instr_valid_i && !ce_i);

endmodule // bws_sequencer
`default_nettype wire

// [design/bws_regs.svh]
// Timing constants and encodings for the block wait sequencer
`ifndef BWS_REGS_SVH
`define BWS_REGS_SVH

// Core clock rate in kHz (200 MHz)
`define BWS_CLK_KHZ        200000
// Time base of the fast timer wait, in ms (0.01 s units)
`define BWS_FAST_UNIT_MS   10
// Time base of the normal timer wait, in ms (0.1 s units)
`define BWS_NORM_UNIT_MS   100
// Number of block programs, 00 to 99
`define BWS_NUM_BLOCKS     100
// Width of a program address
`define BWS_ADDR_W         16
// Width of a BCD set value, four digits
`define BWS_SETV_W         16
// Width of the binary unit count, holds 9999
`define BWS_CNT_W          14
// Largest value of one BCD digit
`define BWS_BCD_MAX        4'h9

`endif

// [design/bws_pkg.sv]
// Types shared by the block wait sequencer
package bws_pkg;

  // Kind of instruction presented by the scan engine
  typedef enum logic [2:0] {
    bws_k_other,
    bws_k_begin,
    bws_k_end,
    bws_k_wait,
    bws_k_wait_not,
    bws_k_timer_normal,
    bws_k_timer_fast
  } bws_kind_e;

  // Data area of a bit operand
  typedef enum logic [2:0] {
    bws_a_io_relay,
    bws_a_special_relay,
    bws_a_aux_bit,
    bws_a_holding_bit,
    bws_a_timer_counter,
    bws_a_link_bit,
    bws_a_data_memory
  } bws_area_e;

endpackage : bws_pkg

// [bench/test_bws_sequencer.sv]
// Self-checking testbench for the block wait sequencer
`timescale 1ns/10ps
`default_nettype none

module test_bws_sequencer;
  import bws_pkg::*;

  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        ce_i = 1'b1;
  logic        instr_valid_i = 1'b0;
  logic [6:0]  block_i = 7'h00;
  logic [15:0] addr_i = 16'h0000;
  bws_kind_e   kind_i = bws_k_other;
  logic        has_bit_i = 1'b0;
  bws_area_e   area_i = bws_a_io_relay;
  logic        bit_i = 1'b0;
  logic        exec_cond_i = 1'b0;
  logic [15:0] set_value_i = 16'h0000;
  logic        dm_range_err_i = 1'b0;
  logic        ack_o, exec_o, skip_o, resume_o, fault_flag_o;
  logic [15:0] resume_addr_o;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n;

  bws_sequencer #(.FAST_UNIT_CYC(4), .NORM_UNIT_CYC(8)) bws_sequencer_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i), .block_i(block_i),
    .addr_i(addr_i), .kind_i(kind_i), .has_bit_i(has_bit_i), .area_i(area_i), .bit_i(bit_i),
    .exec_cond_i(exec_cond_i), .set_value_i(set_value_i), .dm_range_err_i(dm_range_err_i), .ack_o(ack_o),
    .exec_o(exec_o), .skip_o(skip_o), .resume_o(resume_o), .resume_addr_o(resume_addr_o),
    .fault_flag_o(fault_flag_o));

  always #2.5 mclk_i = ~mclk_i;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Answer bits: ack 10, exec 08, skip 04, resume 02, fault 01
  function automatic logic [15:0] ans(input logic [15:0] mask);
    ans = {11'h000, ack_o, exec_o, skip_o, resume_o, fault_flag_o} & mask;
  endfunction

  task automatic pres(input logic [6:0] b, input logic [15:0] a, input bws_kind_e k,
                      input logic hb, input logic bt, input logic ec, input logic [15:0] sv);
    block_i = b;
    addr_i = a;
    kind_i = k;
    has_bit_i = hb;
    bit_i = bt;
    exec_cond_i = ec;
    set_value_i = sv;
    instr_valid_i = 1'b1;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic idle();
    instr_valid_i = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic wait_met();
    pres(7'd0, 16'h0001, bws_k_begin, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("begin", ans(16'h001F), 16'h0018);
    for (int i = 0; i < 6; i++) begin
      area_i = bws_area_e'(i);
      pres(7'd0, 16'h0002, bws_k_wait, 1'b1, 1'b1, 1'b0, 16'h0000);
      check("wait_area", ans(16'h001F), 16'h0018);
    end
    area_i = bws_a_io_relay;
    pres(7'd0, 16'h0003, bws_k_wait, 1'b0, 1'b0, 1'b1, 16'h0000);
    check("wait_cond", ans(16'h001F), 16'h0018);
    pres(7'd0, 16'h0004, bws_k_wait_not, 1'b1, 1'b0, 1'b0, 16'h0000);
    check("wait_not_met", ans(16'h001F), 16'h0018);
    pres(7'd0, 16'h0005, bws_k_end, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("end", ans(16'h001C), 16'h0018);
    idle();
  endtask

  task automatic wait_unmet();
    pres(7'd1, 16'h0010, bws_k_begin, 1'b0, 1'b0, 1'b0, 16'h0000);
    pres(7'd1, 16'h0011, bws_k_other, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("before_wait", ans(16'h001C), 16'h0018);
    pres(7'd1, 16'h0015, bws_k_wait, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("wait_unmet", ans(16'h0014), 16'h0014);
    pres(7'd1, 16'h0010, bws_k_begin, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("resume", ans(16'h001A), 16'h0012);
    check("resume_addr", resume_addr_o, 16'h0015);
    pres(7'd1, 16'h0016, bws_k_other, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("suspended_other", ans(16'h0018), 16'h0010);
    pres(7'd1, 16'h0015, bws_k_wait, 1'b1, 1'b0, 1'b1, 16'h0000);
    check("still_waiting", ans(16'h0014), 16'h0014);
    pres(7'd1, 16'h0015, bws_k_wait, 1'b1, 1'b1, 1'b0, 16'h0000);
    check("wait_now_met", ans(16'h001C), 16'h0018);
    pres(7'd1, 16'h0016, bws_k_other, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("after_wait", ans(16'h001C), 16'h0018);
    pres(7'd1, 16'h0017, bws_k_end, 1'b0, 1'b0, 1'b0, 16'h0000);
    pres(7'd1, 16'h0010, bws_k_begin, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("restart", ans(16'h001A), 16'h0018);
    pres(7'd1, 16'h0015, bws_k_wait_not, 1'b1, 1'b1, 1'b0, 16'h0000);
    check("wait_not_unmet", ans(16'h0014), 16'h0014);
    idle();
  endtask

  task automatic timer_run(input logic [6:0] b, input bws_kind_e k, input logic [15:0] sv,
                           input int lo, input int hi);
    pres(b, 16'h0020, bws_k_begin, 1'b0, 1'b0, 1'b0, 16'h0000);
    pres(b, 16'h0021, bws_k_other, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("timer_first_part", ans(16'h001C), 16'h0018);
    pres(b, 16'h0022, k, 1'b0, 1'b0, 1'b0, sv);
    check("timer_arm", ans(16'h0015), 16'h0014);
    n = 0;
    do begin
      pres(b, 16'h0022, k, 1'b0, 1'b0, 1'b0, sv);
      n++;
    end while (skip_o === 1'b1 && n < 200);
    check("timer_span", {15'h0000, (n >= lo && n <= hi)}, 16'h0001);
    check("timer_done", ans(16'h001D), 16'h0018);
    pres(b, 16'h0023, bws_k_end, 1'b0, 1'b0, 1'b0, 16'h0000);
    pres(b, 16'h0020, bws_k_begin, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("timer_repeat", ans(16'h001A), 16'h0018);
    idle();
  endtask

  task automatic faults();
    pres(7'd4, 16'h0030, bws_k_timer_fast, 1'b0, 1'b0, 1'b0, 16'h99A9);
    check("non_bcd", ans(16'h0015), 16'h0011);
    pres(7'd4, 16'h0030, bws_k_timer_normal, 1'b0, 1'b0, 1'b0, 16'hF000);
    check("non_bcd_norm", ans(16'h0015), 16'h0011);
    dm_range_err_i = 1'b1;
    pres(7'd4, 16'h0030, bws_k_timer_fast, 1'b0, 1'b0, 1'b0, 16'h0001);
    check("dm_range", ans(16'h0015), 16'h0011);
    dm_range_err_i = 1'b0;
    pres(7'd4, 16'h0030, bws_k_timer_fast, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("zero_set", ans(16'h001D), 16'h0018);
    pres(7'd5, 16'h0040, bws_k_timer_fast, 1'b0, 1'b0, 1'b0, 16'h9999);
    check("max_set", ans(16'h0015), 16'h0014);
    area_i = bws_a_data_memory;
    pres(7'h4, 16'h0031, bws_k_wait, 1'b1, 1'b1, 1'b0, 16'h0000);
    check("dm_bit_area", ans(16'h0015), 16'h0011);
    area_i = bws_a_io_relay;
    idle();
  endtask

  // Low clock enable must take nothing and hold the answer
  task automatic freeze();
    ce_i = 1'b0;
    pres(7'h6, 16'h0050, bws_k_wait, 1'b1, 1'b0, 1'b0, 16'h0000);
    check("frozen", ans(16'h001F), 16'h0000);
    ce_i = 1'b1;
    pres(7'h6, 16'h0050, bws_k_begin, 1'b0, 1'b0, 1'b0, 16'h0000);
    check("frozen_record", ans(16'h001A), 16'h0018);
    idle();
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(5 * 5000);
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    @(posedge mclk_i);
    #1;
    check("reset_out", ans(16'h001F), 16'h0000);
    wait_met();
    wait_unmet();
    timer_run(7'h2, bws_k_timer_fast, 16'h0002, 3, 10);
    timer_run(7'h3, bws_k_timer_normal, 16'h0002, 7, 18);
    faults();
    freeze();
    finish_test();
  end
endmodule // test_bws_sequencer

`default_nettype wire
